// ==== gtm_pkg.sv ====
// package: constants and types for the timing and time mark block
package gtm_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned PPS_PERIOD_S = 1;
  localparam int unsigned PPS_CYCLES   = CLK_HZ * PPS_PERIOD_S;
  localparam int unsigned PPS_HIGH_MS  = 100;
  localparam int unsigned PPS_HIGH_CYC = CLK_HZ / 1000 * PPS_HIGH_MS;
  localparam int unsigned RAW_RATE_HZ  = 5;
  localparam int unsigned RAW_CYCLES   = CLK_HZ / RAW_RATE_HZ;
  // second pulse: half period in cycles, 1/60 Hz to 25 MHz
  localparam int unsigned TP2_SLOW_S   = 60;
  localparam int unsigned TP2_FAST_HZ  = 10_000_000;
  localparam logic [31:0] TP2_HALF_MAX = 32'(CLK_HZ / 2 * TP2_SLOW_S);
  localparam logic [31:0] TP2_HALF_MIN = 32'(1);
  localparam logic [31:0] TP2_HALF_RST = 32'(CLK_HZ / 2);
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned TIME_W  = 32;
  localparam int unsigned SUB_W   = 32;
  localparam int unsigned CNT_W   = 16;
  localparam int unsigned DEV_W   = 16;
  localparam int unsigned SAT_W   = 4;
  localparam int unsigned MEAS_W  = 32;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  // timing mode setting from the host
  typedef enum logic [1:0] {
    GTM_MODE_OFF    = 2'h0,
    GTM_MODE_SURVEY = 2'h1,
    GTM_MODE_FIXED  = 2'h3
  } gtm_mode_t;

  // internal timing state, gray along off->survey->fixed
  typedef enum logic [1:0] {
    GTM_ST_OFF    = 2'h0,
    GTM_ST_SURVEY = 2'h1,
    GTM_ST_FIXED  = 2'h3
  } gtm_state_t;
endpackage : gtm_pkg

// ==== gtm_tp2_gen.sv ====
// second time pulse generator: programmable square wave
module gtm_tp2_gen
  import gtm_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_en,
  input  wire logic [31:0] i_half_period,
  output logic             o_pulse
);
  import gtm_pkg::*;

  logic [31:0] count;
  logic [31:0] half_clamped;
  wire         too_small = i_half_period < TP2_HALF_MIN;
  wire         too_large = i_half_period > TP2_HALF_MAX;
  wire         at_end    = count >= (half_clamped - TP2_HALF_MIN);
  wire  [31:0] next_count = at_end ? 32'h0 : count + 32'h1;

  // out-of-range settings are clamped, never silently stall
  always_comb
  begin
    half_clamped = i_half_period;
    if (too_small)
      half_clamped = TP2_HALF_MIN;
    else if (too_large)
      half_clamped = TP2_HALF_MAX;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n || !i_en)
    begin
      count   <= 32'h0;
      o_pulse <= 1'b0;
    end
    else
    begin
      count <= next_count;
      if (at_end)
        o_pulse <= ~o_pulse;
    end
  end
endmodule : gtm_tp2_gen

// ==== gtm_timing.sv ====
// timing block: time mode, time pulses, time mark and raw records
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module gtm_timing
  import gtm_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  input  gtm_pkg::gtm_mode_t     i_mode,
  input  wire logic              i_fixed_pos_load,
  input  wire logic [DEV_W-1:0]  i_dev_max,
  input  wire logic [DEV_W-1:0]  i_dev_now,
  input  wire logic              i_dev_valid,
  input  wire logic [SAT_W-1:0]  i_sats_used,
  input  wire logic [31:0]       i_tp2_half_period,
  input  wire logic              i_mark_cfg_wr,
  input  wire logic              i_mark_cfg_en,
  input  wire logic              i_use_utc,
  input  wire logic [TIME_W-1:0] i_utc_offset_s,
  input  wire logic              i_external_mark_input,
  input  wire logic [MEAS_W-1:0] i_carrier_phase,
  input  wire logic [MEAS_W-1:0] i_code_phase,
  input  wire logic [MEAS_W-1:0] i_doppler,
  output gtm_pkg::gtm_state_t    o_state,
  output logic                   o_corr_active,
  output logic                   o_timing_valid,
  output logic                   o_timepulse,
  output logic                   o_timepulse2,
  output logic                   o_mark_valid,
  output logic                   o_mark_rising,
  output logic [TIME_W-1:0]      o_mark_sec,
  output logic [SUB_W-1:0]       o_mark_ns,
  output logic [CNT_W-1:0]       o_mark_rise_count,
  output logic [CNT_W-1:0]       o_mark_fall_count,
  output logic                   o_raw_valid,
  output logic [MEAS_W-1:0]      o_raw_carrier,
  output logic [MEAS_W-1:0]      o_raw_code,
  output logic [MEAS_W-1:0]      o_raw_doppler
);
  import gtm_pkg::*;

  // ---------------------------------------------------------------
  // time mode state machine
  // ---------------------------------------------------------------
  gtm_state_t state;
  gtm_state_t next_state;

  wire survey_done = i_dev_valid && (i_dev_now <= i_dev_max);

  always_comb
  begin
    next_state = state;
    case (i_mode)
      GTM_MODE_OFF:    next_state = GTM_ST_OFF;
      GTM_MODE_SURVEY:
      begin
        // once converged the survey result is kept as fixed
        if (state == GTM_ST_SURVEY && survey_done)
          next_state = GTM_ST_FIXED;
        else if (state == GTM_ST_OFF)
          next_state = GTM_ST_SURVEY;
      end
      GTM_MODE_FIXED:
      begin
        if (i_fixed_pos_load)
          next_state = GTM_ST_FIXED;
      end
      default:         next_state = GTM_ST_OFF;
    endcase
  end

  wire next_corr = (next_state == GTM_ST_FIXED);
  // the fixed state keeps timing with a single satellite, other states need four
  wire sats_ok   = next_corr ? (i_sats_used != '0)
                             : (i_sats_used >= SAT_W'(4));

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      state          <= GTM_ST_OFF;
      o_state        <= GTM_ST_OFF;
      o_corr_active  <= 1'b0;
      o_timing_valid <= 1'b0;
    end
    else
    begin
      state          <= next_state;
      o_state        <= next_state;
      o_corr_active  <= next_corr;
      o_timing_valid <= sats_ok;
    end
  end

  // ---------------------------------------------------------------
  // primary pulse and local time base
  // ---------------------------------------------------------------
  logic [31:0]       pps_cnt;
  logic [TIME_W-1:0] sec_cnt;
  wire               pps_wrap  = pps_cnt == 32'(PPS_CYCLES - 1);
  wire  [31:0]       next_pps  = pps_wrap ? 32'h0 : pps_cnt + 32'h1;
  wire               pps_high  = next_pps < 32'(PPS_HIGH_CYC);

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      pps_cnt     <= 32'h0;
      sec_cnt     <= '0;
      o_timepulse <= 1'b0;
    end
    else
    begin
      pps_cnt     <= next_pps;
      o_timepulse <= pps_high;
      if (pps_wrap)
        sec_cnt <= sec_cnt + TIME_W'(1);
    end
  end

  gtm_tp2_gen u_tp2
  (
    .i_ref_clk     (i_ref_clk),
    .i_rst_n       (i_rst_n),
    .i_en          (1'b1),
    .i_half_period (i_tp2_half_period),
    .o_pulse       (o_timepulse2)
  );

  // ---------------------------------------------------------------
  // time mark on the external input
  // ---------------------------------------------------------------
  logic mark_en;
  logic mark_prev;
  wire  mark_rise = i_external_mark_input && !mark_prev;
  wire  mark_fall = !i_external_mark_input && mark_prev;
  wire  mark_edge = mark_en && (mark_rise || mark_fall);
  // 20 ns stamp resolution, well below a microsecond
  wire [SUB_W-1:0]  stamp_ns  = SUB_W'(pps_cnt * CLK_PERIOD_NS);
  wire [TIME_W-1:0] stamp_sec = i_use_utc ? sec_cnt - i_utc_offset_s
                                          : sec_cnt;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      mark_en           <= 1'b0;
      mark_prev         <= 1'b0;
      o_mark_valid      <= 1'b0;
      o_mark_rising     <= 1'b0;
      o_mark_sec        <= '0;
      o_mark_ns         <= '0;
      o_mark_rise_count <= '0;
      o_mark_fall_count <= '0;
    end
    else
    begin
      if (i_mark_cfg_wr)
        mark_en <= i_mark_cfg_en;
      mark_prev    <= i_external_mark_input;
      o_mark_valid <= mark_edge;
      if (mark_edge)
      begin
        o_mark_rising <= mark_rise;
        o_mark_sec    <= stamp_sec;
        o_mark_ns     <= stamp_ns;
      end
      if (mark_edge && mark_rise)
        o_mark_rise_count <= o_mark_rise_count + CNT_ONE;
      if (mark_edge && mark_fall)
        o_mark_fall_count <= o_mark_fall_count + CNT_ONE;
    end
  end

  // ---------------------------------------------------------------
  // raw measurement records
  // ---------------------------------------------------------------
  logic [31:0] raw_cnt;
  wire         raw_tick = raw_cnt == 32'(RAW_CYCLES - 1);

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      raw_cnt       <= 32'h0;
      o_raw_valid   <= 1'b0;
      o_raw_carrier <= '0;
      o_raw_code    <= '0;
      o_raw_doppler <= '0;
    end
    else
    begin
      raw_cnt     <= raw_tick ? 32'h0 : raw_cnt + 32'h1;
      o_raw_valid <= raw_tick;
      if (raw_tick)
      begin
        o_raw_carrier <= i_carrier_phase;
        o_raw_code    <= i_code_phase;
        o_raw_doppler <= i_doppler;
      end
    end
  end
endmodule : gtm_timing

// ==== gtm_checker.sv ====
// checker: timing mode, time mark and pulse properties
module gtm_checker
  import gtm_pkg::*;
(
  input wire logic              i_ref_clk,
  input wire logic              i_rst_n,
  input gtm_pkg::gtm_mode_t     i_mode,
  input wire logic              i_fixed_pos_load,
  input wire logic [DEV_W-1:0]  i_dev_max,
  input wire logic [DEV_W-1:0]  i_dev_now,
  input wire logic              i_dev_valid,
  input wire logic [31:0]       i_tp2_half_period,
  input wire logic              i_external_mark_input,
  input wire logic [MEAS_W-1:0] i_carrier_phase,
  input gtm_pkg::gtm_state_t    o_state,
  input wire logic              o_corr_active,
  input wire logic              o_timepulse2,
  input wire logic              o_mark_valid,
  input wire logic              o_mark_rising,
  input wire logic [CNT_W-1:0]  o_mark_rise_count,
  input wire logic              o_raw_valid,
  input wire logic [MEAS_W-1:0] o_raw_carrier
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  wire dev_ok = i_dev_valid && (i_dev_now <= i_dev_max);
  // cycles since reset or since the last raw record, saturating
  logic [31:0] raw_gap;
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      raw_gap <= 32'h0;
    else if (o_raw_valid)
      raw_gap <= 32'h1;
    else if (raw_gap != 32'hFFFF_FFFF)
      raw_gap <= raw_gap + 32'h1;
  end
  sequence in_survey;
    o_state == GTM_ST_SURVEY && i_mode == GTM_MODE_SURVEY;
  endsequence
  // ---------------------------------------------------------------
  // timing mode
  // ---------------------------------------------------------------
  mode_off_a: assert property (
    i_mode == GTM_MODE_OFF |=> o_state == GTM_ST_OFF)
    else $error("state not off after mode off");
  survey_go_a: assert property (
    o_state == GTM_ST_OFF && i_mode == GTM_MODE_SURVEY
    |=> o_state == GTM_ST_SURVEY) else $error("survey not entered");
  survey_hold_a: assert property (
    in_survey ##0 !dev_ok |=> o_state == GTM_ST_SURVEY)
    else $error("survey left before limit");
  survey_fix_a: assert property (
    in_survey ##0 dev_ok |=> o_state == GTM_ST_FIXED)
    else $error("survey did not end in fixed");
  load_fix_a: assert property (
    i_mode == GTM_MODE_FIXED && i_fixed_pos_load
    |=> o_state == GTM_ST_FIXED) else $error("load did not fix");
  corr_state_a: assert property (
    o_corr_active == (o_state == GTM_ST_FIXED))
    else $error("corrections disagree with state");
  // ---------------------------------------------------------------
  // pulses, marks, raw records
  // ---------------------------------------------------------------
  tp2_half_a: assert property (
    $changed(o_timepulse2) && i_tp2_half_period == 32'h3
    |=> $stable(o_timepulse2)[*2] ##1 $changed(o_timepulse2))
    else $error("second pulse half period wrong");
  mark_dir_a: assert property (
    o_mark_valid |-> o_mark_rising == $past(i_external_mark_input))
    else $error("mark edge direction wrong");
  rise_cnt_a: assert property (
    o_mark_valid && o_mark_rising
    |-> o_mark_rise_count == $past(o_mark_rise_count) + CNT_ONE)
    else $error("rise count not stepped");
  raw_data_a: assert property (
    o_raw_valid |-> o_raw_carrier == $past(i_carrier_phase))
    else $error("raw carrier not sampled");
  raw_rate_a: assert property (
    o_raw_valid |-> raw_gap == 32'(RAW_CYCLES))
    else $error("raw record rate wrong");
endmodule : gtm_checker

// ==== gtm_ext_equip.sv ====
// model of outside equipment driving the mark pin
module gtm_ext_equip
(
  input  wire logic i_ref_clk,
  input  wire logic i_fire,
  output logic      o_mark
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_mark = 1'b0;
  // toggles so rising and falling edges alternate
  always @(posedge i_ref_clk)
    if (i_fire)
      o_mark <= ~o_mark;
endmodule : gtm_ext_equip

// ==== gtm_timing_tb_top.sv ====
// testbench: timing block scenarios with mark source model
module gtm_timing_tb_top import gtm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, load = 0, dv = 0, wr = 0, en = 0, fire = 0;
  gtm_mode_t mode = GTM_MODE_OFF;
  logic [15:0] dmax = 16'h0010, dnow = 16'h0020;
  int n_mismatch = 0, n_checks = 0, cyc = 0, tog = 0, t0;
  logic [3:0] sats = 4'h4;
  logic [31:0] ns0;
  int n_mv = 0, n_rv = 0;
  wire pin, corr, tp2, tv, tp, mv, mr, rv;
  wire [31:0] msec, mns;
  wire [15:0] rc, fc;
  gtm_state_t st;
  always #10 clk = ~clk;
  always @(posedge tp2) tog++;
  gtm_ext_equip u_gtm_ext_equip (.i_ref_clk(clk), .i_fire(fire),
    .o_mark(pin));
  gtm_timing u_gtm_timing (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_mode(mode), .i_fixed_pos_load(load), .i_dev_max(dmax),
    .i_dev_now(dnow), .i_dev_valid(dv), .i_sats_used(sats),
    .i_tp2_half_period(32'h3), .i_mark_cfg_wr(wr), .i_mark_cfg_en(en),
    .i_use_utc(1'b0), .i_utc_offset_s(32'h0),
    .i_external_mark_input(pin), .i_carrier_phase(32'(cyc)),
    .i_code_phase(~32'(cyc)), .i_doppler(32'(cyc) ^ 32'h5A5A),
    .o_state(st), .o_corr_active(corr), .o_timing_valid(tv),
    .o_timepulse(tp), .o_timepulse2(tp2), .o_mark_valid(mv),
    .o_mark_rising(mr), .o_mark_sec(msec), .o_mark_ns(mns),
    .o_mark_rise_count(rc), .o_mark_fall_count(fc), .o_raw_valid(rv),
    .o_raw_carrier(), .o_raw_code(), .o_raw_doppler());
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc_n(int n);
    repeat (n) @(posedge clk);
  endtask : cyc_n
  task automatic edge_out;
    fire <= 1'b1;
    cyc_n(1);
    fire <= 1'b0;
    cyc_n(4);
  endtask : edge_out
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  // bounded run: the sequence needs about 115 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    n_mv <= n_mv + int'(mv);
    n_rv <= n_rv + int'(rv);
    if (cyc == 3000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  initial
  begin
    cyc_n(5);
    chk("pulse_rst", 32'(tp), 32'h0);
    rst_n <= 1'b1;
    cyc_n(2);
    chk("state_rst", 32'(st), 32'(GTM_ST_OFF));
    edge_out();
    edge_out();
    chk("rise_cnt_off", 32'(rc), 32'h0);
    wr <= 1'b1;
    en <= 1'b1;
    cyc_n(1);
    wr <= 1'b0;
    cyc_n(1);
    edge_out();
    ns0 = mns;
    // edges are five clocks apart, so stamps step by five periods
    repeat (3)
    begin
      edge_out();
      chk("mark_ns_step", mns - ns0, 32'(5 * CLK_PERIOD_NS));
      ns0 = mns;
    end
    chk("rise_cnt", 32'(rc), 32'h2);
    chk("fall_cnt", 32'(fc), 32'h2);
    chk("mark_n", 32'(n_mv), 32'h4);
    chk("mark_dir", 32'(mr), 32'h0);
    chk("mark_sec", msec, 32'h0);
    chk("pulse_high", 32'(tp), 32'h1);
    mode <= GTM_MODE_SURVEY;
    dv <= 1'b1;
    cyc_n(4);
    chk("survey", 32'(st), 32'(GTM_ST_SURVEY));
    chk("corr_survey", 32'(corr), 32'h0);
    dnow <= dmax;
    cyc_n(3);
    chk("fixed", 32'(st), 32'(GTM_ST_FIXED));
    chk("corr_fixed", 32'(corr), 32'h1);
    mode <= GTM_MODE_OFF;
    sats <= 4'h1;
    cyc_n(3);
    chk("off", 32'(st), 32'(GTM_ST_OFF));
    chk("tv_off", 32'(tv), 32'h0);
    mode <= GTM_MODE_FIXED;
    cyc_n(3);
    chk("no_load", 32'(st), 32'(GTM_ST_OFF));
    load <= 1'b1;
    cyc_n(1);
    load <= 1'b0;
    cyc_n(2);
    chk("loaded", 32'(st), 32'(GTM_ST_FIXED));
    chk("tv_fixed", 32'(tv), 32'h1);
    // sample off the edge so the pulse count never races
    #1 t0 = tog;
    cyc_n(60);
    #1 chk("tp2_rises", 32'(tog - t0), 32'hA);
    // run is far shorter than one record interval
    chk("raw_none", 32'(n_rv), 32'h0);
    close_out();
  end
endmodule : gtm_timing_tb_top
bind gtm_timing gtm_checker u_gtm_checker (
  .i_ref_clk             (i_ref_clk),
  .i_rst_n               (i_rst_n),
  .i_mode                (i_mode),
  .i_fixed_pos_load      (i_fixed_pos_load),
  .i_dev_max             (i_dev_max),
  .i_dev_now             (i_dev_now),
  .i_dev_valid           (i_dev_valid),
  .i_tp2_half_period     (i_tp2_half_period),
  .i_external_mark_input (i_external_mark_input),
  .i_carrier_phase       (i_carrier_phase),
  .o_state               (o_state),
  .o_corr_active         (o_corr_active),
  .o_timepulse2          (o_timepulse2),
  .o_mark_valid          (o_mark_valid),
  .o_mark_rising         (o_mark_rising),
  .o_mark_rise_count     (o_mark_rise_count),
  .o_raw_valid           (o_raw_valid),
  .o_raw_carrier         (o_raw_carrier)
);
